// ==== src/pca_modules.sv ====
// compare/capture modules of the counter array with an apb register slave
// What this block does
// - capture when capture bits set and match, toggle and pwm bits clear: rising, falling or both edges.
// - valid pin edge copies shared counter bytes into the capture register.
// - interrupt request only while module flag and its interrupt enable set.
// - match bit set: counter equal to compare register sets module flag.
// - toggle bit set: counter match inverts the module pin.
// - comparator enable plus match bit selects software timer mode.
// - comparator enable, match and toggle select high-speed output mode.
// - comparator enable plus pulse-width bit, others clear, selects 8-bit pwm.
// - pwm pin low while counter low byte below duty byte, else high.
// - pwm duty reloads from high byte when counter low byte wraps.
// - all modules compare against the one shared counter.
// - only module four has the watchdog; otherwise it works normally.
// - watchdog match raises internal reset, never the external reset pin.
// - watchdog active only in compare mode with watchdog enable set.
// - clearing watchdog enable before a match prevents the reset.
// - flag interrupt enable gates the module flag onto its request.
// - mode bit seven reserved: reads zero here, software writes zero.
`timescale 1ns/1ps
`default_nettype none
module pca_modules
    import pca_pkg::*;
#(
    parameter int NUM_MODULES = MODULES
)(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire count_t                 counter,
    input  wire logic [NUM_MODULES-1:0] pin_in,
    output logic      [NUM_MODULES-1:0] pin_out,
    output logic      [NUM_MODULES-1:0] pin_oe,
    output logic      [NUM_MODULES-1:0] irq_request,
    output logic                        internal_reset
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (NUM_MODULES != MODULES) begin : g_bad_count
        $error("module count must match the state layout");
    end

    pca_state_t s;
    pca_state_t next_s;

    logic [MODULES-1:0] rise_v;
    logic [MODULES-1:0] fall_v;
    logic [MODULES-1:0] match_v;
    logic [MODULES-1:0] wrap_v;
    logic [MODULES-1:0] duty_v;
    logic [MODULES-1:0] cap_mode_v;
    logic [MODULES-1:0] cap_ev_v;
    logic [MODULES-1:0] mat_v;
    logic [MODULES-1:0] tog_v;
    logic [MODULES-1:0] pwm_v;
    logic [MODULES-1:0] eccf_v;
    logic               wdt_fire;

    // ------------------------------------------------------------
    // per-module decode, comparator and pin synchroniser
    // ------------------------------------------------------------
    for (genvar i = 0; i < MODULES; i++) begin : g_mod
        logic [MODE_W-1:0] m;
        assign m = s.mode[i];

        module_compare u_cmp (
            .mode         (s.mode[i]),
            .ccap         (s.ccap[i]),
            .counter      (counter),
            .counter_prev (s.cnt_prev),
            .match        (match_v[i]),
            .wrap         (wrap_v[i]),
            .duty_high    (duty_v[i])
        );

        pin_sync u_sync (
            .pclk    (pclk),
            .presetn (presetn),
            .pin     (pin_in[i]),
            .rise    (rise_v[i]),
            .fall    (fall_v[i])
        );

        // capture needs the match, toggle and pwm bits clear
        assign cap_mode_v[i] = (m[FLD_CAPP] | m[FLD_CAPN]) & ~m[FLD_MAT]
                             & ~m[FLD_TOG] & ~m[FLD_PWM];
        assign cap_ev_v[i] = cap_mode_v[i] & ((m[FLD_CAPP] & rise_v[i])
                           | (m[FLD_CAPN] & fall_v[i]));
        // compare modes keep the capture bits clear
        assign mat_v[i] = m[FLD_MAT] & ~m[FLD_CAPP] & ~m[FLD_CAPN];
        assign tog_v[i] = m[FLD_TOG] & m[FLD_MAT] & ~m[FLD_CAPP]
                        & ~m[FLD_CAPN];
        assign pwm_v[i] = m[FLD_ECOM] & m[FLD_PWM] & ~m[FLD_CAPP] & ~m[FLD_CAPN]
                        & ~m[FLD_MAT] & ~m[FLD_TOG] & ~m[FLD_ECCF];
        assign eccf_v[i] = m[FLD_ECCF];
    end

    // watchdog lives on one module only; without enable it is a plain compare
    assign wdt_fire = s.wdt_en & match_v[WDT_MODULE] & mat_v[WDT_MODULE];

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic       setup;
    logic       wr;
    logic [2:0] idx;
    logic       idx_ok;
    logic       hit_mode;
    logic       hit_ccap;
    logic       hit_flag;
    logic       hit_ctrl;
    logic       hit_pin;
    logic       mapped;
    logic [31:0] rdata;

    assign setup    = psel & ~penable;
    assign wr       = psel & penable & s.pready & pwrite;
    assign idx      = paddr[4:2];
    assign idx_ok   = (32'(idx) < MODULES) & (paddr[1:0] == 2'h0);
    assign hit_mode = idx_ok & (paddr[7:5] == MODE_BASE[7:5]);
    assign hit_ccap = idx_ok & (paddr[7:5] == CCAP_BASE[7:5]);
    assign hit_flag = (paddr == FLAG_OFS);
    assign hit_ctrl = (paddr == CTRL_OFS);
    assign hit_pin  = (paddr == PIN_OFS);
    assign mapped   = hit_mode | hit_ccap | hit_flag | hit_ctrl | hit_pin;

    // read mux; the reserved mode bit and unmapped words read zero
    always_comb begin
        rdata = 32'h0000_0000;
        for (int i = 0; i < MODULES; i++) begin
            if (hit_mode && 32'(idx) == i) begin
                rdata[MODE_W-1:0] = s.mode[i];
            end
            if (hit_ccap && 32'(idx) == i) begin
                rdata[15:0] = s.ccap[i];
            end
        end
        if (hit_flag) begin
            rdata[MODULES-1:0] = s.flag;
        end
        if (hit_ctrl) begin
            rdata[FLD_WDT] = s.wdt_en;
        end
        if (hit_pin) begin
            rdata[MODULES-1:0]           = s.pin_out;
            rdata[MODULES+7:8]           = s.pin_oe;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s          = s;
        next_s.cnt_prev = counter;
        next_s.pready   = setup;
        next_s.pslverr  = setup & ~mapped;
        if (setup) begin
            next_s.prdata = rdata;
        end
        // software writes first, so hardware events below win
        if (wr && hit_flag) begin
            next_s.flag = s.flag & ~pwdata[MODULES-1:0];
        end
        if (wr && hit_ctrl) begin
            next_s.wdt_en = pwdata[FLD_WDT];
        end
        for (int i = 0; i < MODULES; i++) begin
            if (wr && hit_mode && 32'(idx) == i) begin
                next_s.mode[i] = pwdata[MODE_W-1:0];
            end
            if (wr && hit_ccap && 32'(idx) == i) begin
                next_s.ccap[i] = pwdata[15:0];
            end
            // glitch-free duty update at the low byte wrap
            if (pwm_v[i] && wrap_v[i]) begin
                next_s.ccap[i][7:0] = s.ccap[i][15:8];
            end
            if (cap_ev_v[i]) begin
                next_s.ccap[i] = counter;
            end
            if (cap_ev_v[i] || (match_v[i] && mat_v[i])) begin
                next_s.flag[i] = 1'b1;
            end
            if (match_v[i] && tog_v[i]) begin
                next_s.toggle[i] = ~s.toggle[i];
            end
            next_s.pin_out[i] = pwm_v[i] ? duty_v[i] : next_s.toggle[i];
            next_s.pin_oe[i]  = pwm_v[i] | tog_v[i];
            next_s.irq[i] = next_s.flag[i] & next_s.mode[i][FLD_ECCF];
        end
        // internal only: no path to the external reset pin exists here
        next_s.wdt_reset = wdt_fire;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            for (int i = 0; i < MODULES; i++) begin
                s.mode[i] <= MODE_RESET;
                s.ccap[i] <= CCAP_RESET;
            end
        end else begin
            s <= next_s;
        end
    end

    assign prdata         = s.prdata;
    assign pready         = s.pready;
    assign pslverr        = s.pslverr;
    assign pin_out        = s.pin_out;
    assign pin_oe         = s.pin_oe;
    assign irq_request    = s.irq;
    assign internal_reset = s.wdt_reset;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    irq_gate_a : assert property (s.irq == (s.flag & eccf_v))
        else $error("interrupt request does not follow flag and enable");

    match_flag_a : assert property ((match_v & mat_v) != '0 |=>
        (s.flag & $past(match_v & mat_v)) == $past(match_v & mat_v))
        else $error("match did not set the module flag");

    toggle_pin_a : assert property (match_v[2] && tog_v[2] && !pwm_v[2] |=>
        pin_out[2] != $past(pin_out[2]))
        else $error("match did not toggle the pin");

    capture_copy_a : assert property (cap_ev_v[0] |=> s.ccap[0] == $past(counter))
        else $error("capture did not copy the counter");

    pwm_level_a : assert property (pwm_v[3] |=>
        pin_out[3] == ($past(counter.low) >= $past(s.ccap[3][7:0])))
        else $error("pwm level wrong for duty byte");

    pwm_reload_a : assert property (pwm_v[3] && wrap_v[3] && !wr |=>
        s.ccap[3][7:0] == $past(s.ccap[3][15:8]))
        else $error("duty byte not reloaded at wrap");

    wdt_fire_a : assert property (wdt_fire |=> internal_reset)
        else $error("watchdog match gave no internal reset");

    wdt_hold_a : assert property (!s.wdt_en |=> !internal_reset)
        else $error("internal reset with watchdog disabled");

    reserved_read_a : assert property (setup && hit_mode |=> prdata[31:MODE_W] == '0)
        else $error("reserved mode bits read nonzero");

    apb_ready_a : assert property (setup |=> pready ##1 !pready)
        else $error("apb answer not one access cycle");

endmodule // pca_modules
`default_nettype wire

// ==== src/pca_pkg.sv ====
// shared constants, field positions and state types for the compare/capture modules
package pca_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int MODULES    = 5;
    localparam int WDT_MODULE = 4;
    localparam int MODE_W     = 7;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_BASE = 8'h00;   // module_mode_control, one word per module
    localparam logic [7:0] CCAP_BASE = 8'h20;   // capture high/low bytes, one word per module
    localparam logic [7:0] FLAG_OFS  = 8'h40;   // counter_flag_register (event flags)
    localparam logic [7:0] CTRL_OFS  = 8'h44;   // counter_mode_register (watchdog_enable)
    localparam logic [7:0] PIN_OFS   = 8'h48;   // pin levels, read only

    // ------------------------------------------------------------
    // module_mode_control field positions
    // ------------------------------------------------------------
    localparam int FLD_ECOM = 6;   // comparator_enable
    localparam int FLD_CAPP = 5;   // rising_capture_enable
    localparam int FLD_CAPN = 4;   // falling_capture_enable
    localparam int FLD_MAT  = 3;   // match_flag_enable
    localparam int FLD_TOG  = 2;   // match_toggle_enable
    localparam int FLD_PWM  = 1;   // pulse_width_mode_enable
    localparam int FLD_ECCF = 0;   // flag_interrupt_enable
    localparam int FLD_WDT  = 0;   // watchdog_enable in counter_mode_register

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_RESET = 7'h00;
    localparam logic [15:0]       CCAP_RESET = 16'h0000;
    localparam logic [7:0]        WRAP_FROM  = 8'hFF;
    localparam logic [7:0]        WRAP_TO    = 8'h00;

    // ------------------------------------------------------------
    // carriers and state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] high;   // counter_high_byte
        logic [7:0] low;    // counter_low_byte
    } count_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_state_t;

    typedef struct packed {
        logic [MODULES-1:0][MODE_W-1:0] mode;
        logic [MODULES-1:0][15:0]       ccap;
        logic [MODULES-1:0]             flag;
        logic [MODULES-1:0]             toggle;
        logic [MODULES-1:0]             pin_out;
        logic [MODULES-1:0]             pin_oe;
        logic [MODULES-1:0]             irq;
        logic                           wdt_en;
        logic                           wdt_reset;
        count_t                         cnt_prev;
        logic                           pready;
        logic                           pslverr;
        logic [31:0]                    prdata;
    } pca_state_t;

endpackage

// ==== src/pin_sync.sv ====
// three-stage pin synchroniser with edge detection on the settled level
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import pca_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output logic      rise,
    output logic      fall
);
    sync_state_t s;
    sync_state_t next_s;

    // ------------------------------------------------------------
    // settle: a change counts once stage two and three agree
    // ------------------------------------------------------------
    always_comb begin
        next_s    = s;
        next_s.s1 = pin;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        if (s.s2 == s.s3) begin
            next_s.level = s.s3;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // edges from consecutive settled samples
    assign rise = (s.s2 == s.s3) & s.s3 & ~s.level;
    assign fall = (s.s2 == s.s3) & ~s.s3 & s.level;
endmodule // pin_sync
`default_nettype wire

// ==== src/module_compare.sv ====
// per-module comparator: match event, low-byte wrap and pwm level
`timescale 1ns/1ps
`default_nettype none
module module_compare
    import pca_pkg::*;
(
    input  wire logic [MODE_W-1:0] mode,
    input  wire logic [15:0]       ccap,
    input  wire count_t            counter,
    input  wire count_t            counter_prev,
    output logic                   match,
    output logic                   wrap,
    output logic                   duty_high
);
    // a match counts once per new counter value, so a slow counter
    // does not toggle or flag on every clock it dwells
    assign match = mode[FLD_ECOM] & ~mode[FLD_PWM] & (counter != counter_prev)
                 & (counter == ccap);
    assign wrap  = (counter_prev.low == WRAP_FROM) & (counter.low == WRAP_TO);
    assign duty_high = (counter.low >= ccap[7:0]);
endmodule // module_compare
`default_nettype wire

// ==== bench/pin_partner.sv ====
// outside world model for the module pins
`timescale 1ns/1ps
`default_nettype none
module pin_partner
    import pca_pkg::*;
(
    input  wire logic [MODULES-1:0] drive,
    input  wire logic [MODULES-1:0] pin_out,
    input  wire logic [MODULES-1:0] pin_oe,
    output logic      [MODULES-1:0] pin_in
);
    // wire level: a driving module wins, so the outside source backs off then
    always_comb begin
        for (int i = 0; i < MODULES; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : drive[i];
        end
    end
endmodule // pin_partner
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the compare/capture modules
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pca_pkg::*;
;
    logic               pclk;
    logic               presetn;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [7:0]         paddr;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    count_t             counter;
    logic [MODULES-1:0] drive;
    logic [MODULES-1:0] pin_in;
    logic [MODULES-1:0] pin_out;
    logic [MODULES-1:0] pin_oe;
    logic [MODULES-1:0] irq_request;
    logic               internal_reset;
    logic               wdt_seen;
    int                 fails;
    int                 cmp_count;
    logic [31:0]        r;
    logic               e;

    pca_modules i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .counter(counter), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .irq_request(irq_request), .internal_reset(internal_reset));
    pin_partner i_pins (.drive(drive), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

    // 25 MHz clock
    always #20 pclk = ~pclk;

    // the reset pulse lasts one cycle, so latch it for the scenario to judge
    always @(posedge pclk) begin
        if (internal_reset === 1'b1) begin
            wdt_seen <= 1'b1;
        end
    end

    // -------------------------------------------------------
    // common tasks
    // -------------------------------------------------------
    task automatic end_of_test();
        if (fails == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) begin
            fails++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // counter moves once, held afterwards
    task automatic set_cnt(input logic [15:0] v);
        @(posedge pclk);
        counter <= v;
        cyc(2);
    endtask

    // -------------------------------------------------------
    // scenarios
    // -------------------------------------------------------
    task automatic t_regs();
        for (int i = 0; i < MODULES; i++) begin
            apb(1'b0, MODE_BASE + 8'(4 * i), 32'h0);
            chk(r, 32'h0);
            apb(1'b0, CCAP_BASE + 8'(4 * i), 32'h0);
            chk(r, 32'h0);
        end
        apb(1'b1, MODE_BASE, 32'h0000_00FF);
        apb(1'b0, MODE_BASE, 32'h0);
        chk(r, 32'h0000_007F);
        apb(1'b1, MODE_BASE, 32'h0000_0000);
        apb(1'b0, 8'hFC, 32'h0);
        chk({31'h0, e}, 32'h1);
    endtask

    task automatic cap_step(input logic lvl, input logic [15:0] c, input logic [15:0] exp);
        set_cnt(c);
        drive[0] <= lvl;
        cyc(8);
        apb(1'b0, CCAP_BASE, 32'h0);
        chk(r, {16'h0, exp});
    endtask

    task automatic t_capture();
        apb(1'b1, MODE_BASE, 32'h20);
        cap_step(1'b1, 16'h1234, 16'h1234);
        cap_step(1'b0, 16'h2222, 16'h1234);
        apb(1'b0, FLAG_OFS, 32'h0);
        chk(r & 32'h1, 32'h1);
        apb(1'b1, MODE_BASE, 32'h10);
        cap_step(1'b1, 16'h3333, 16'h1234);
        cap_step(1'b0, 16'h4444, 16'h4444);
        apb(1'b1, MODE_BASE, 32'h30);
        cap_step(1'b1, 16'h5555, 16'h5555);
    endtask

    task automatic t_timer();
        apb(1'b1, CCAP_BASE + 8'h04, 32'h0100);
        apb(1'b1, MODE_BASE + 8'h04, 32'h49);
        set_cnt(16'h00FF);
        chk({31'h0, irq_request[1]}, 32'h0);
        set_cnt(16'h0100);
        chk({31'h0, irq_request[1]}, 32'h1);
        apb(1'b0, FLAG_OFS, 32'h0);
        chk(r & 32'h2, 32'h2);
        apb(1'b1, FLAG_OFS, 32'h2);
        cyc(1);
        chk({31'h0, irq_request[1]}, 32'h0);
    endtask

    task automatic t_hso();
        apb(1'b1, CCAP_BASE + 8'h08, 32'h0200);
        apb(1'b1, MODE_BASE + 8'h08, 32'h4C);
        set_cnt(16'h0200);
        chk({30'h0, pin_oe[2], pin_out[2]}, 32'h3);
        set_cnt(16'h0201);
        set_cnt(16'h0200);
        chk({31'h0, pin_out[2]}, 32'h0);
        apb(1'b0, PIN_OFS, 32'h0);
        chk(r, 32'h0000_0400);
    endtask

    task automatic t_pwm();
        apb(1'b1, CCAP_BASE + 8'h0C, 32'h8040);
        apb(1'b1, MODE_BASE + 8'h0C, 32'h42);
        set_cnt(16'h0030);
        chk({30'h0, pin_oe[3], pin_out[3]}, 32'h2);
        set_cnt(16'h0040);
        chk({31'h0, pin_out[3]}, 32'h1);
        set_cnt(16'h00FF);
        set_cnt(16'h0100);
        set_cnt(16'h0170);
        chk({31'h0, pin_out[3]}, 32'h0);
        apb(1'b0, CCAP_BASE + 8'h0C, 32'h0);
        chk(r & 32'hFF, 32'h80);
    endtask

    task automatic t_watchdog();
        apb(1'b1, CCAP_BASE + 8'h10, 32'h0500);
        apb(1'b1, MODE_BASE + 8'h10, 32'h48);
        set_cnt(16'h0400);
        wdt_seen <= 1'b0;
        set_cnt(16'h0500);
        cyc(2);
        chk({31'h0, wdt_seen}, 32'h0);
        apb(1'b0, FLAG_OFS, 32'h0);
        chk(r & 32'h10, 32'h10);
        apb(1'b1, CTRL_OFS, 32'h1);
        set_cnt(16'h0400);
        apb(1'b1, CTRL_OFS, 32'h0);
        set_cnt(16'h0500);
        cyc(2);
        chk({31'h0, wdt_seen}, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h1);
        set_cnt(16'h0400);
        set_cnt(16'h0500);
        cyc(2);
        chk({31'h0, wdt_seen}, 32'h1);
    endtask

    // -------------------------------------------------------
    // main sequence and watchdog
    // -------------------------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        counter = 16'h0000;
        drive = 5'h00;
        wdt_seen = 1'b0;
        fails = 0;
        cmp_count = 0;
        cyc(4);
        presetn <= 1'b1;
        t_regs();
        t_capture();
        t_timer();
        t_hso();
        t_pwm();
        t_watchdog();
        end_of_test();
    end

    // a hang ends the run well after the scenarios should be over
    initial begin
        #(40 * 20000);
        fails++;
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
